// ===== dv/jbce_chain_model.sv
// Scan chain partner: one bypass stage between tdi and tdo.
// Assumes tck idles low and the engine samples tdo while tck is high.
`timescale 1ns/10ps
`default_nettype none
module jbce_chain_model (
    input  wire logic tck,
    input  wire logic tdi,
    output logic      tdo
);
    logic byp_q = 1'b0; // Bypass stage; a single TAP is on the chain.
    initial tdo = 1'b0;
    // Capture on the rise and launch on the fall, as a real TAP does.
    always @(posedge tck) byp_q <= tdi;
    always @(negedge tck) tdo <= byp_q;
endmodule : jbce_chain_model
`default_nettype wire

// ===== dv/jbce_engine_tb.sv
// Bench for the scan engine: pushes packets, checks pins and responses.
// Assumes the package and the chain model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module jbce_engine_tb;
    logic        clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, en = 1'b1;
    logic [3:0]  psel = 4'h0, rsel = 4'h0; // One-hot push and pop widths.
    logic [31:0] wdata = 32'h0, resp_rdata, d;
    logic        cmd_push_done, resp_pop_done, tck, tms, tdi, tdo;
    logic [4:0]  cmd_level, resp_level;
    logic [15:0] w;
    logic [1:0]  pin_q[$];  // Expected tms and tdi at each tck rise.
    logic [31:0] resp_q[$]; // Expected response words.
    int          mismatches = 0, checks_done = 0, seed = 32'h5202, k, i, n, t;
    always #12.5 clk = ~clk;
    always #62.5 link_clk = ~link_clk;
    jbce_engine jbce_engine_i (.clk(clk), .rst_b(rst_b), .clk_en(en), .link_clk(link_clk),
        .cmd_push_one_byte(psel[0]), .cmd_push_two_bytes(psel[1]),
        .cmd_push_three_bytes(psel[2]), .cmd_push_four_bytes(psel[3]), .cmd_wdata(wdata),
        .cmd_push_done(cmd_push_done), .cmd_level(cmd_level),
        .resp_pop_one_byte(rsel[0]), .resp_pop_two_bytes(rsel[1]),
        .resp_pop_three_bytes(rsel[2]), .resp_pop_four_bytes(rsel[3]),
        .resp_rdata(resp_rdata), .resp_pop_done(resp_pop_done), .resp_level(resp_level),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    jbce_chain_model jbce_chain_model_i (.tck(tck), .tdi(tdi), .tdo(tdo));
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Hold a request until its done pulse, with a bounded wait.
    task automatic hs(input logic [3:0] p, input logic [3:0] r, input logic [31:0] v);
        @(negedge clk);
        wdata = v;
        psel = p;
        rsel = r;
        k = 0;
        do begin @(negedge clk); k++; end
        while (cmd_push_done !== 1'b1 && resp_pop_done !== 1'b1 && k < 400);
        if (k >= 400) begin mismatches++; summarize(); end
        psel = 4'h0;
        rsel = 4'h0;
    endtask : hs
    // Every tck rise must match the oldest expected pin pair; extras fail.
    always @(posedge tck) begin
        if (pin_q.size() == 0) check(32'h0, 32'h1, "spare tck");
        else check({30'h0, tms, tdi}, {30'h0, pin_q.pop_front()}, "tms tdi");
    end
    always @(negedge clk) begin
        if (resp_pop_done === 1'b1) check(resp_rdata, resp_q.pop_front(), "resp");
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        // Reserved opcodes first, then a four-bit move with tdi high.
        for (i = 0; i < 4; i++) pin_q.push_back({i < 2, 1'b1});
        hs(4'h8, 4'h0, 32'h53e0c0a0);
        $display("moves done");
        // A 21-bit captured scan whose last data byte arrives late.
        d = $random(seed);
        for (i = 0; i < 21; i++) pin_q.push_back({i == 20, d[i]});
        resp_q.push_back({11'h0, d[19:0], 1'b1});
        hs(4'h8, 4'h0, {d[15:0], 16'h148c});
        repeat (1300) @(negedge clk);
        // Freeze the block while it waits for the last byte; it must resume intact.
        en = 1'b0;
        repeat (100) @(negedge clk);
        check({27'h0, resp_level}, 32'h2, "resp level frozen");
        en = 1'b1;
        repeat (100) @(negedge clk);
        hs(4'h1, 4'h0, {27'h0, d[20:16]});
        $display("scan done");
        // Packed and fixed-tdi forms, the last one with random packed data.
        for (t = 0; t < 4; t++) begin
            w = t == 0 ? 16'h8883 : t == 1 ? 16'ha580 : t == 2 ? 16'h028b : {2'b11, d[5:0], 8'h88};
            n = w[15] ? 0 : w[14:8] + 1;
            if (w[15]) for (i = 1; i < 7; i++) if (w[8+i]) n = i;
            for (i = 0; i < n; i++) pin_q.push_back({w[3] && i == n - 1, w[0] ? w[1] : w[8+i]});
            hs(4'h2, 4'h0, {16'h0, w});
        end
        // A 128-bit fixed-tdi capture overfills the response FIFO, so the scan must stall.
        for (i = 0; i < 128; i++) pin_q.push_back(2'b00);
        resp_q.push_back({31'h0, d[5]});
        for (i = 0; i < 3; i++) resp_q.push_back(32'h0);
        hs(4'h2, 4'h0, 32'h00007f85);
        for (k = 0; resp_level != 5'h10 && k < 30000; k++) @(negedge clk);
        if (k >= 30000) begin mismatches++; summarize(); end
        repeat (500) @(negedge clk);
        check(pin_q.size(), 32'h10, "bits left at stall");
        hs(4'h0, 4'h4, 32'h0);
        for (k = 0; pin_q.size() > 0 && k < 30000; k++) @(negedge clk);
        if (k >= 30000) begin mismatches++; summarize(); end
        $display("short scans done");
        for (t = 0; t < 4; t++) hs(4'h0, 4'h8, 32'h0);
        check({27'h0, resp_level}, 32'h0, "resp level");
        check({27'h0, cmd_level}, 32'h0, "cmd level");
        $display("response done");
        summarize();
    end
endmodule : jbce_engine_tb
`default_nettype wire

// ===== verilog/jbce_engine.sv
// Byte-command scan engine: command and response FIFOs on clk,
// scan engine on link_clk, toggle handshakes between the two.
// Assumes a free-running link_clk and host strobes held until done.
// Summary of operation
// - Write strobe enqueues one to four bytes.
// - Captured TDO bytes readable via four pops.
// - Commands are bytes: bit7 0 moves, 100 scans.
// - State-move packet: one-five TMS bits, one TDI.
// - Highest set bit of 5:1 marks length.
// - State-move TDI held at bit 6.
// - TMS bits LSB first, one TCK each.
// - State-move packets capture no TDO.
// - Scan packet: header, length, up to sixteen data.
// - Scan TMS low except last cycle's bit 3.
// - Header bit 2 enables TDO capture.
// - Header bit 0 holds TDI at bit 1.
// - Fixed TDI means no data bytes.
// - Normal length byte: bits 6:0 plus one.
// - Normal length, variable TDI: data bytes follow.
// - Normal length, fixed TDI: packet is two bytes.
// - Packed length byte for one to six cycles.
// - Packed form with fixed TDI: length only.
// - Packed: marker in 6:1, data below, bit0 first.
// - Data bytes consumed LSB first, whole bytes.
// - TDO packed LSB first, zero padded, pushed promptly.
// - Full response FIFO stops TCK until space.
`timescale 1ns/10ps
`default_nettype none
module jbce_engine #(
    parameter int CMD_DEPTH  = jbce_pkg::CMD_DEPTH,
    parameter int RESP_DEPTH = jbce_pkg::RESP_DEPTH,
    parameter int TCK_HALF   = jbce_pkg::TCK_HALF_CYC,
    parameter int CAW        = $clog2(CMD_DEPTH),
    parameter int RAW        = $clog2(RESP_DEPTH)
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic         link_clk,
    input  wire logic         cmd_push_one_byte,
    input  wire logic         cmd_push_two_bytes,
    input  wire logic         cmd_push_three_bytes,
    input  wire logic         cmd_push_four_bytes,
    input  wire logic [31:0]  cmd_wdata,
    output logic              cmd_push_done,
    output logic      [CAW:0] cmd_level,
    input  wire logic         resp_pop_one_byte,
    input  wire logic         resp_pop_two_bytes,
    input  wire logic         resp_pop_three_bytes,
    input  wire logic         resp_pop_four_bytes,
    output logic      [31:0]  resp_rdata,
    output logic              resp_pop_done,
    output logic      [RAW:0] resp_level,
    output logic              tck,
    output logic              tms,
    output logic              tdi,
    input  wire logic         tdo
);

    localparam int PCW = $clog2(2 * TCK_HALF);
    localparam logic [PCW-1:0] PC_RISE = PCW'(TCK_HALF - 1);
    localparam logic [PCW-1:0] PC_LAST = PCW'(2 * TCK_HALF - 1);

    // Host-clock state, including synchronisers of link toggles.
    typedef struct packed {
        logic       pdone;   // Push accepted last cycle.
        logic       rdone;   // Pop served last cycle.
        logic       fpend;   // Command byte popping, data next.
        logic       cack;    // Command byte handed over.
        logic [7:0] cbyte;   // Byte handed to the link side.
        logic       rack;    // Response byte taken.
        logic [2:0] creq_s;
        logic       creq_v;
        logic [2:0] rreq_s;
        logic       rreq_v;
    } jbce_hs_t;

    // Link-clock state of the scan engine.
    typedef struct packed {
        jbce_pkg::jbce_st_t st;
        jbce_pkg::jbce_ph_t ph;
        logic [2:0]     en_s;
        logic           en_v;
        logic [2:0]     cack_s;
        logic           cack_v;
        logic [2:0]     rack_s;
        logic           rack_v;
        logic [2:0]     tdo_s;
        logic           tdo_v;
        logic           creq;    // Toggles to ask for a byte.
        logic           rreq;    // Toggles to offer obyte.
        logic           scan;    // Packet is a scan, not a move.
        logic [3:0]     hdr;     // Scan header control bits.
        logic           mv_tdi;  // TDI level of a move packet.
        logic [7:0]     dat;     // TMS or TDI bits, next in bit 0.
        logic [3:0]     dcnt;    // Bits left in the data byte.
        logic           dmode;   // TDI comes from data bytes.
        logic [7:0]     left;    // Bits left in the packet.
        logic [7:0]     obyte;   // TDO byte being packed.
        logic [2:0]     ocnt;
        logic [PCW-1:0] pc;      // Phase inside one TCK cycle.
        logic           tck;
        logic           tms;
        logic           tdi;
    } jbce_lk_t;

    jbce_hs_t hs_q;
    jbce_hs_t hs_d;
    jbce_lk_t lk_q;
    jbce_lk_t lk_d;

    logic [2:0]   cpush_n;
    logic [2:0]   rpop_n;
    logic [2:0]   cpop_n;
    logic [2:0]   rpush_n;
    logic [31:0]  cmd_rd;
    logic [CAW:0] ccnt;
    logic [2:0]   wn;
    logic [2:0]   rn;
    logic [2:0]   hp;
    logic [7:0]   b;

    // Byte count of a strobe group; the widest strobe wins.
    function automatic logic [2:0] nbytes(input logic [3:0] s);
        nbytes = s[3] ? 3'h4 : s[2] ? 3'h3 : s[1] ? 3'h2 :
                 s[0] ? 3'h1 : 3'h0;
    endfunction : nbytes

    // Position of the highest set bit among 6:1, zero if none.
    function automatic logic [2:0] hi_pos(input logic [6:0] v);
        hi_pos = 3'h0;
        for (int i = 1; i < 7; i++) begin
            if (v[i]) hi_pos = 3'(i);
        end
    endfunction : hi_pos

    // After a bit: new byte needed, or keep shifting.
    function automatic jbce_pkg::jbce_st_t after(
        input logic [7:0] left, input logic dm, input logic [3:0] dc);
        after = (left == 8'h00 || (dm && dc == 4'h0)) ?
                jbce_pkg::ST_FETCH : jbce_pkg::ST_SHIFT;
    endfunction : after

    ////////////////////////////////////////////////////////////////
    // Two byte FIFOs on the host clock.
    jbce_fifo #(.DEPTH(CMD_DEPTH)) u_cmd (
        .clk    (clk),
        .rst_b  (rst_b),
        .en     (clk_en),
        .push_n (cpush_n),
        .wdata  (cmd_wdata),
        .pop_n  (cpop_n),
        .rdata  (cmd_rd),
        .count  (ccnt)
    );

    jbce_fifo #(.DEPTH(RESP_DEPTH)) u_resp (
        .clk    (clk),
        .rst_b  (rst_b),
        .en     (clk_en),
        .push_n (rpush_n),
        .wdata  ({24'h000000, lk_q.obyte}),
        .pop_n  (rpop_n),
        .rdata  (resp_rdata),
        .count  (resp_level)
    );

    ////////////////////////////////////////////////////////////////
    // Host side: strobes stall until room or data is there, so a
    // write or read never splits across the FIFO boundary.
    always_comb begin
        hs_d    = hs_q;
        cpush_n = 3'h0;
        rpop_n  = 3'h0;
        cpop_n  = 3'h0;
        rpush_n = 3'h0;
        wn = nbytes({cmd_push_four_bytes, cmd_push_three_bytes,
                     cmd_push_two_bytes, cmd_push_one_byte});
        rn = nbytes({resp_pop_four_bytes, resp_pop_three_bytes,
                     resp_pop_two_bytes, resp_pop_one_byte});
        if (clk_en) begin
            hs_d.creq_s = {hs_q.creq_s[1:0], lk_q.creq};
            hs_d.rreq_s = {hs_q.rreq_s[1:0], lk_q.rreq};
            if (hs_q.creq_s[1] == hs_q.creq_s[2]) hs_d.creq_v = hs_q.creq_s[2];
            if (hs_q.rreq_s[1] == hs_q.rreq_s[2]) hs_d.rreq_v = hs_q.rreq_s[2];
            hs_d.pdone = 1'h0;
            hs_d.rdone = 1'h0;
            // Done pulse blocks the cycle in which the host drops it.
            if (wn != 3'h0 && !hs_q.pdone &&
                (CAW+1)'(CMD_DEPTH) - ccnt >= (CAW+1)'(wn)) begin
                cpush_n    = wn;
                hs_d.pdone = 1'h1;
            end
            if (rn != 3'h0 && !hs_q.rdone && resp_level >= (RAW+1)'(rn)) begin
                rpop_n     = rn;
                hs_d.rdone = 1'h1;
            end
            // Fetch: pop one byte, take it from the read word next cycle.
            if (hs_q.fpend) begin
                hs_d.cbyte = cmd_rd[7:0];
                hs_d.cack  = ~hs_q.cack;
                hs_d.fpend = 1'h0;
            end else if (hs_q.creq_v != hs_q.cack && ccnt != '0) begin
                cpop_n     = 3'h1;
                hs_d.fpend = 1'h1;
            end
            // A full FIFO leaves the offer pending; the engine waits.
            if (hs_q.rreq_v != hs_q.rack &&
                resp_level < (RAW+1)'(RESP_DEPTH)) begin
                rpush_n   = 3'h1;
                hs_d.rack = ~hs_q.rack;
            end
        end
    end

    // Host-side register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_q <= '0;
        end else begin
            hs_q <= hs_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Link side: decode bytes, then shift bit by bit. TCK only runs
    // in ST_SHIFT, so waits for bytes or FIFO room stop the clock.
    always_comb begin
        lk_d = lk_q;
        b    = hs_q.cbyte;
        hp   = 3'h0;
        lk_d.en_s = {lk_q.en_s[1:0], clk_en};
        if (lk_q.en_s[1] == lk_q.en_s[2]) lk_d.en_v = lk_q.en_s[2];
        if (lk_q.en_v) begin
            lk_d.cack_s = {lk_q.cack_s[1:0], hs_q.cack};
            lk_d.rack_s = {lk_q.rack_s[1:0], hs_q.rack};
            lk_d.tdo_s  = {lk_q.tdo_s[1:0], tdo};
            if (lk_q.cack_s[1] == lk_q.cack_s[2]) lk_d.cack_v = lk_q.cack_s[2];
            if (lk_q.rack_s[1] == lk_q.rack_s[2]) lk_d.rack_v = lk_q.rack_s[2];
            if (lk_q.tdo_s[1] == lk_q.tdo_s[2]) lk_d.tdo_v = lk_q.tdo_s[2];
            case (lk_q.st)
                jbce_pkg::ST_FETCH: begin
                    lk_d.creq = ~lk_q.creq;
                    lk_d.st   = jbce_pkg::ST_WAITB;
                end
                jbce_pkg::ST_WAITB: begin
                    // Stay here, state intact, until a byte arrives.
                    if (lk_q.cack_v == lk_q.creq) begin
                        lk_d.st = jbce_pkg::ST_FETCH;
                        case (lk_q.ph)
                            jbce_pkg::PH_CMD: begin
                                if (!b[jbce_pkg::KIND_BIT]) begin
                                    hp          = hi_pos({1'h0, b[jbce_pkg::TMS_FLD_HI:0]});
                                    lk_d.scan   = 1'h0;
                                    lk_d.mv_tdi = b[jbce_pkg::TMS_TDI_BIT];
                                    lk_d.dat    = {3'h0, b[4:0]};
                                    lk_d.left   = {5'h00, hp};
                                    lk_d.dmode  = 1'h0;
                                    if (hp != 3'h0) lk_d.st = jbce_pkg::ST_SHIFT;
                                end else if (b[jbce_pkg::OP_HI:jbce_pkg::OP_LO]
                                             == jbce_pkg::SCAN_OP) begin
                                    lk_d.scan = 1'h1;
                                    lk_d.hdr  = b[jbce_pkg::HDR_HI:0];
                                    lk_d.ph   = jbce_pkg::PH_LEN;
                                end
                                // Other opcodes fall through and are dropped.
                            end
                            jbce_pkg::PH_LEN: begin
                                lk_d.ph = jbce_pkg::PH_CMD;
                                if (!b[jbce_pkg::LEN_FMT_BIT]) begin
                                    lk_d.left  = {1'h0, b[jbce_pkg::LEN_HI:0]} + 8'h01;
                                    lk_d.dmode = !lk_q.hdr[jbce_pkg::HDR_FIXED_IN_FLAG];
                                    lk_d.dcnt  = 4'h0;
                                    if (lk_d.dmode) begin
                                        lk_d.ph = jbce_pkg::PH_DATA;
                                    end else begin
                                        lk_d.st = jbce_pkg::ST_SHIFT;
                                    end
                                end else begin
                                    // Packed: marker sets length, bits below are TDI.
                                    hp         = hi_pos(b[jbce_pkg::LEN_HI:0]);
                                    lk_d.left  = {5'h00, hp};
                                    lk_d.dat   = {2'h0, b[jbce_pkg::PACK_HI:0]};
                                    lk_d.dmode = 1'h0;
                                    if (hp != 3'h0) lk_d.st = jbce_pkg::ST_SHIFT;
                                end
                            end
                            default: begin
                                lk_d.dat  = b;
                                lk_d.dcnt = jbce_pkg::BYTE_BITS;
                                lk_d.st   = jbce_pkg::ST_SHIFT;
                            end
                        endcase
                    end
                end
                jbce_pkg::ST_SHIFT: begin
                    lk_d.pc = lk_q.pc + PCW'(1);
                    if (lk_q.pc == '0) begin
                        // Set up TMS and TDI while TCK is low.
                        if (lk_q.scan) begin
                            lk_d.tms = (lk_q.left == 8'h01) &&
                                       lk_q.hdr[jbce_pkg::HDR_TMS];
                            lk_d.tdi = lk_q.hdr[jbce_pkg::HDR_FIXED_IN_FLAG] ?
                                       lk_q.hdr[jbce_pkg::HDR_TDI] : lk_q.dat[0];
                        end else begin
                            lk_d.tms = lk_q.dat[0];
                            lk_d.tdi = lk_q.mv_tdi;
                        end
                    end
                    if (lk_q.pc == PC_RISE) lk_d.tck = 1'h1;
                    if (lk_q.pc == PC_LAST) begin
                        lk_d.tck  = 1'h0;
                        lk_d.pc   = '0;
                        lk_d.dat  = {1'h0, lk_q.dat[7:1]};
                        lk_d.left = lk_q.left - 8'h01;
                        if (lk_q.dmode) lk_d.dcnt = lk_q.dcnt - 4'h1;
                        lk_d.st = after(lk_d.left, lk_d.dmode, lk_d.dcnt);
                        lk_d.ph = (lk_d.left == 8'h00) ?
                                  jbce_pkg::PH_CMD : jbce_pkg::PH_DATA;
                        // Capture only in scans that ask for it.
                        if (lk_q.scan && lk_q.hdr[jbce_pkg::HDR_CAPTURE_OUT_FLAG]) begin
                            lk_d.obyte[lk_q.ocnt] = lk_q.tdo_v;
                            lk_d.ocnt = lk_q.ocnt + 3'h1;
                            if (lk_q.ocnt == jbce_pkg::BYTE_LAST ||
                                lk_q.left == 8'h01) begin
                                lk_d.rreq = ~lk_q.rreq;
                                lk_d.st   = jbce_pkg::ST_RPUSH;
                            end
                        end
                    end
                end
                default: begin
                    // Hold TCK low until the byte is in the FIFO.
                    if (lk_q.rack_v == lk_q.rreq) begin
                        lk_d.obyte = 8'h00;
                        lk_d.ocnt  = 3'h0;
                        lk_d.st    = after(lk_q.left, lk_q.dmode, lk_q.dcnt);
                    end
                end
            endcase
        end
    end

    // Link-side register.
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_q <= '{st: jbce_pkg::ST_FETCH, ph: jbce_pkg::PH_CMD, default: '0};
        end else begin
            lk_q <= lk_d;
        end
    end

    assign cmd_push_done = hs_q.pdone;
    assign resp_pop_done = hs_q.rdone;
    assign cmd_level     = ccnt;
    assign tck           = lk_q.tck;
    assign tms           = lk_q.tms;
    assign tdi           = lk_q.tdi;

    ////////////////////////////////////////////////////////////////
    // Checks on driven behaviour.
    wire shift_bit = lk_q.st == jbce_pkg::ST_SHIFT && lk_q.pc != '0;

    push_done_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd_push_done |=> !cmd_push_done) else $error("push done not one cycle");
    tms_tdi_hold_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        shift_bit && !lk_q.scan |-> tdi == lk_q.mv_tdi) else $error("move tdi changed");
    tms_no_capture_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        lk_q.st == jbce_pkg::ST_SHIFT && !lk_q.scan |=> $stable(lk_q.rreq))
        else $error("move packet captured tdo");
    scan_tms_low_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        shift_bit && lk_q.scan && lk_q.left > 8'h01 |-> !tms) else $error("scan tms high early");
    scan_tms_last_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        shift_bit && lk_q.scan && lk_q.left == 8'h01 |-> tms == lk_q.hdr[jbce_pkg::HDR_TMS])
        else $error("scan last tms wrong");
    fixed_tdi_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        shift_bit && lk_q.scan && lk_q.hdr[jbce_pkg::HDR_FIXED_IN_FLAG]
        |-> tdi == lk_q.hdr[jbce_pkg::HDR_TDI]) else $error("fixed tdi wrong");
    stall_tck_low_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        lk_q.st == jbce_pkg::ST_RPUSH |-> !tck) else $error("tck ran while stalled");
    tck_high_time_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        $rose(tck) |-> tck[*4] ##1 !tck) else $error("tck high time wrong");

    scan_capture_c: cover property (@(posedge link_clk) disable iff (!rst_b)
        lk_q.st == jbce_pkg::ST_RPUSH && lk_q.left == 8'h00);
    move_packet_c: cover property (@(posedge link_clk) disable iff (!rst_b)
        $rose(tck) && !lk_q.scan);
    resp_stall_c: cover property (@(posedge link_clk) disable iff (!rst_b)
        lk_q.st == jbce_pkg::ST_RPUSH [*8]);

endmodule : jbce_engine
`default_nettype wire

// ===== verilog/jbce_fifo.sv
// Byte FIFO taking and giving up to four bytes per cycle.
// Assumes callers never push past full nor pop past the count.
`timescale 1ns/10ps
`default_nettype none
module jbce_fifo #(
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        en,
    input  wire logic [2:0]  push_n,
    input  wire logic [31:0] wdata,
    input  wire logic [2:0]  pop_n,
    output logic      [31:0] rdata,
    output logic      [AW:0] count
);

    // Whole state: storage, pointers, fill count and read word.
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0]         wp;
        logic [AW-1:0]         rp;
        logic [AW:0]           cnt;
        logic [31:0]           rd;
    } jbce_fifo_t;

    jbce_fifo_t f_q;
    jbce_fifo_t f_d;

    ////////////////////////////////////////////////////////////////
    // Byte lanes write and read at pointer plus lane; unused read
    // lanes return zero so narrow reads show clean upper bits.
    always_comb begin
        f_d = f_q;
        if (en) begin
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < push_n) begin
                    f_d.mem[AW'(f_q.wp + AW'(i))] = wdata[i*8 +: 8];
                end
                f_d.rd[i*8 +: 8] = (3'(i) < pop_n) ?
                                   f_q.mem[AW'(f_q.rp + AW'(i))] : 8'h00;
            end
            f_d.wp  = AW'(f_q.wp + AW'(push_n));
            f_d.rp  = AW'(f_q.rp + AW'(pop_n));
            f_d.cnt = (AW+1)'(f_q.cnt + (AW+1)'(push_n) - (AW+1)'(pop_n));
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    assign rdata = f_q.rd;
    assign count = f_q.cnt;

endmodule : jbce_fifo
`default_nettype wire

// ===== verilog/jbce_pkg.sv
// Shared constants and types of the byte-command scan engine.
// Assumes one host clock and one free-running link clock.
`default_nettype none
package jbce_pkg;

    // FIFO depths in bytes, powers of two.
    localparam int CMD_DEPTH  = 16;
    localparam int RESP_DEPTH = 16;

    // Link clock period and wanted TCK half period, in ns.
    localparam int LINK_PERIOD_NS = 125;
    localparam int TCK_HALF_NS    = 500;
    localparam int TCK_HALF_CYC   = TCK_HALF_NS / LINK_PERIOD_NS;

    // Command byte fields.
    localparam int       KIND_BIT     = 7;
    localparam int       TMS_TDI_BIT  = 6;
    localparam int       TMS_FLD_HI   = 5;
    localparam int       OP_HI        = 7;
    localparam int       OP_LO        = 5;
    localparam logic [2:0] SCAN_OP    = 3'h4;
    localparam int       HDR_HI       = 3;
    localparam int       HDR_TMS      = 3;
    localparam int       HDR_CAPTURE_OUT_FLAG     = 2;
    localparam int       HDR_TDI      = 1;
    localparam int       HDR_FIXED_IN_FLAG     = 0;

    // Length byte fields.
    localparam int       LEN_FMT_BIT  = 7;
    localparam int       LEN_HI       = 6;
    localparam int       PACK_HI      = 5;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [2:0] BYTE_LAST  = 3'h7;

    // Engine states, one-hot.
    typedef enum logic [3:0] {
        ST_FETCH = 4'h1,
        ST_WAITB = 4'h2,
        ST_SHIFT = 4'h4,
        ST_RPUSH = 4'h8
    } jbce_st_t;

    // Which byte of a packet is expected next, one-hot.
    typedef enum logic [2:0] {
        PH_CMD  = 3'h1,
        PH_LEN  = 3'h2,
        PH_DATA = 3'h4
    } jbce_ph_t;

endpackage : jbce_pkg
`default_nettype wire
